// ===== core/sem_host_consts.vh
`ifndef SEM_HOST_CONSTS_VH
`define SEM_HOST_CONSTS_VH

// Host clock period
`define CLK_NS 40

// Semaphore port timing, nanoseconds (least times)
`define T_ADDR_SETUP_NS 10
`define T_WR_PULSE_NS 50
`define T_WR_HOLD_NS 10
`define T_RD_ACCESS_NS 55
`define T_RECOVER_NS 20

// Cycle counts, rounded up to whole cycles
`define ADDR_SETUP_CYC ((`T_ADDR_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_PULSE_CYC ((`T_WR_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_HOLD_CYC ((`T_WR_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_ACCESS_CYC ((`T_RD_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
// Extra cycles for the two-flop input synchroniser
`define SYNC_CYC 2

// Command codes
`define OP_READ 2'h0
`define OP_CLAIM 2'h1
`define OP_RELEASE 2'h2
`define OP_INIT 2'h3

// Flag count and index width
`define FLAG_COUNT 8
`define FLAG_IDX_W 3
`define LAST_FLAG 3'h7

// Default values
`define RETRY_DEFAULT 8'h04

`endif

// ===== core/sem_sync2.v
`timescale 1ns/10ps
module sem_sync2 #(
  parameter WIDTH = 16
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Bus is stable while the device holds its read latch, so per-bit sync is safe
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// ===== core/sem_host.v
`timescale 1ns/10ps
`include "sem_host_consts.vh"

module sem_host #(
  parameter DATA_W = 16,
  parameter ADDR_W = 14,
  parameter [7:0] RETRY_MAX = `RETRY_DEFAULT
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [2:0] cmd_index_i,
  output wire cmd_ready_o,
  output wire done_o,
  output wire granted_o,
  output wire flag_value_o,
  output wire chip_enable_n_o,
  output wire flag_space_select_n_o,
  output wire output_enable_n_o,
  output wire read_write_n_o,
  output wire [ADDR_W-1:0] flag_index_bits_o,
  output wire [DATA_W-1:0] data_o,
  output wire data_oe_b_o,
  input wire [DATA_W-1:0] data_i
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 4'h0;
  localparam ST_WR_SET = 4'h1;
  localparam ST_WR_PULSE = 4'h2;
  localparam ST_WR_HOLD = 4'h3;
  localparam ST_RD_WAIT = 4'h4;
  localparam ST_RD_SAMPLE = 4'h5;
  localparam ST_RECOVER = 4'h6;
  localparam ST_DONE = 4'h7;

  reg [3:0] state_ff;
  reg [1:0] op_ff;
  reg [2:0] idx_ff;
  reg wdata_ff;
  reg was_read_ff;
  reg withdraw_ff;
  reg [7:0] tries_ff;
  reg [3:0] cnt_ff;
  reg sem_n_ff;
  reg oe_n_ff;
  reg rw_n_ff;
  reg data_oe_b_ff;
  reg done_ff;
  reg granted_ff;
  reg flag_ff;

  wire [DATA_W-1:0] data_sync;

  sem_sync2 #(
    .WIDTH(DATA_W)
  ) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(data_i),
    .sync_o(data_sync)
  );

  function cnt_hit;
    input [3:0] cnt;
    input integer limit;
    begin
      cnt_hit = ({28'h0, cnt} >= (limit - 1));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      op_ff <= `OP_READ;
      idx_ff <= 3'h0;
      wdata_ff <= 1'b1;
      was_read_ff <= 1'b0;
      withdraw_ff <= 1'b0;
      tries_ff <= 8'h00;
      cnt_ff <= 4'h0;
      sem_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      rw_n_ff <= 1'b1;
      data_oe_b_ff <= 1'b1;
      done_ff <= 1'b0;
      granted_ff <= 1'b0;
      flag_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Select and chip enable both high: device port in standby
          sem_n_ff <= 1'b1;
          oe_n_ff <= 1'b1;
          rw_n_ff <= 1'b1;
          data_oe_b_ff <= 1'b1;
          cnt_ff <= 4'h0;
          withdraw_ff <= 1'b0;
          if (cmd_valid_i) begin
            op_ff <= cmd_op_i;
            idx_ff <= (cmd_op_i == `OP_INIT) ? 3'h0 : cmd_index_i;
            tries_ff <= RETRY_MAX;
            granted_ff <= 1'b0;
            sem_n_ff <= 1'b0;
            if (cmd_op_i == `OP_READ) begin
              oe_n_ff <= 1'b0;
              state_ff <= ST_RD_WAIT;
            end else begin
              // Zero requests, one releases
              wdata_ff <= (cmd_op_i == `OP_CLAIM) ? 1'b0 : 1'b1;
              data_oe_b_ff <= 1'b0;
              state_ff <= ST_WR_SET;
            end
          end
        end
        ST_WR_SET: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_hit(cnt_ff, `ADDR_SETUP_CYC)) begin
            cnt_ff <= 4'h0;
            rw_n_ff <= 1'b0;
            state_ff <= ST_WR_PULSE;
          end
        end
        ST_WR_PULSE: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_hit(cnt_ff, `WR_PULSE_CYC)) begin
            cnt_ff <= 4'h0;
            rw_n_ff <= 1'b1;
            state_ff <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_hit(cnt_ff, `WR_HOLD_CYC)) begin
            cnt_ff <= 4'h0;
            sem_n_ff <= 1'b1;
            data_oe_b_ff <= 1'b1;
            was_read_ff <= 1'b0;
            state_ff <= ST_RECOVER;
          end
        end
        ST_RD_WAIT: begin
          // Access time plus synchroniser delay before the bit is trusted
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_hit(cnt_ff, `RD_ACCESS_CYC + `SYNC_CYC)) begin
            cnt_ff <= 4'h0;
            state_ff <= ST_RD_SAMPLE;
          end
        end
        ST_RD_SAMPLE: begin
          // Every data bit carries the flag; bit zero suffices
          flag_ff <= data_sync[0];
          // Drop both strobes so the next poll sees a fresh latch
          sem_n_ff <= 1'b1;
          oe_n_ff <= 1'b1;
          was_read_ff <= 1'b1;
          state_ff <= ST_RECOVER;
        end
        ST_RECOVER: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_hit(cnt_ff, `RECOVER_CYC)) begin
            cnt_ff <= 4'h0;
            state_ff <= ST_DONE;
            if (!was_read_ff) begin
              if (op_ff == `OP_INIT && idx_ff != `LAST_FLAG) begin
                idx_ff <= idx_ff + 3'h1;
                sem_n_ff <= 1'b0;
                data_oe_b_ff <= 1'b0;
                state_ff <= ST_WR_SET;
              end else if (op_ff == `OP_CLAIM && !withdraw_ff) begin
                // Write first, then read back; never read-then-write
                sem_n_ff <= 1'b0;
                oe_n_ff <= 1'b0;
                state_ff <= ST_RD_WAIT;
              end
            end else if (op_ff == `OP_CLAIM) begin
              if (!flag_ff) begin
                granted_ff <= 1'b1;
              end else if (tries_ff != 8'h00) begin
                // Keep polling; a pending request may be handed over
                tries_ff <= tries_ff - 8'h01;
                sem_n_ff <= 1'b0;
                oe_n_ff <= 1'b0;
                state_ff <= ST_RD_WAIT;
              end else begin
                // Withdraw pending request so the system cannot hang
                withdraw_ff <= 1'b1;
                wdata_ff <= 1'b1;
                sem_n_ff <= 1'b0;
                data_oe_b_ff <= 1'b0;
                state_ff <= ST_WR_SET;
              end
            end
          end
        end
        ST_DONE: begin
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_ready_o = (state_ff == ST_IDLE);
  assign done_o = done_ff;
  assign granted_o = granted_ff;
  assign flag_value_o = flag_ff;
  // Array never selected by this controller
  assign chip_enable_n_o = 1'b1;
  assign flag_space_select_n_o = sem_n_ff;
  assign output_enable_n_o = oe_n_ff;
  assign read_write_n_o = rw_n_ff;
  assign flag_index_bits_o = {{(ADDR_W-`FLAG_IDX_W){1'b0}}, idx_ff};
  assign data_o = {{(DATA_W-1){1'b0}}, wdata_ff};
  assign data_oe_b_o = data_oe_b_ff;

endmodule

// ===== bench/sem_host_assertions.sv
`timescale 1ns/10ps
module sem_host_checker #(parameter DATA_W = 16, parameter ADDR_W = 14) (
  input wire clock_i,
  input wire rst_b_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [2:0] cmd_index_i,
  input wire cmd_ready_o,
  input wire done_o,
  input wire granted_o,
  input wire flag_value_o,
  input wire chip_enable_n_o,
  input wire flag_space_select_n_o,
  input wire output_enable_n_o,
  input wire read_write_n_o,
  input wire [ADDR_W-1:0] flag_index_bits_o,
  input wire [DATA_W-1:0] data_o,
  input wire data_oe_b_o,
  input wire [DATA_W-1:0] data_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire sel = !flag_space_select_n_o;
  sequence s_take; cmd_valid_i && cmd_ready_o && cmd_op_i == 2'h1; endsequence
  sequence s_wr; !read_write_n_o && sel; endsequence
  sequence s_rd; !output_enable_n_o && sel; endsequence
  property p_ce; chip_enable_n_o; endproperty
  a_ce: assert property (p_ce) else $error("array enable low");
  property p_addr; sel |-> flag_index_bits_o[ADDR_W-1:3] == 0; endproperty
  a_addr: assert property (p_addr) else $error("upper address set");
  property p_wd; !read_write_n_o |-> sel && !data_oe_b_o && data_o[DATA_W-1:1] == 0; endproperty
  a_wd: assert property (p_wd) else $error("bad write cycle");
  property p_rlen; $fell(output_enable_n_o) |-> !output_enable_n_o [*4]; endproperty
  a_rlen: assert property (p_rlen) else $error("read too short");
  property p_gap; $rose(output_enable_n_o) |-> flag_space_select_n_o; endproperty
  a_gap: assert property (p_gap) else $error("no gap between reads");
  property p_claim; s_take |-> ##[1:4] s_wr ##[1:12] s_rd; endproperty
  a_claim: assert property (p_claim) else $error("claim not write then read");
  property p_grant; done_o && granted_o |-> !flag_value_o; endproperty
  a_grant: assert property (p_grant) else $error("grant on one");
  property p_idle; cmd_ready_o |-> flag_space_select_n_o && read_write_n_o; endproperty
  a_idle: assert property (p_idle) else $error("idle not standby");
endmodule
bind sem_host sem_host_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk (.*);

// ===== bench/sem_dev_model.sv
`timescale 1ns/10ps
module sem_dev_model (
  input wire sel_n_i,
  input wire oe_n_i,
  input wire rw_n_i,
  input wire [2:0] idx_i,
  input wire wbit_i,
  input wire o_wr_i,
  input wire [2:0] o_idx_i,
  input wire o_val_i,
  output wire [15:0] data_o,
  output wire [7:0] o_view_o
);
  // Power-up state left dirty on purpose, so init must clean it
  reg [7:0] rh = 8'h00;
  reg [7:0] ro = 8'h00;
  reg [7:0] oh = 8'hff;
  reg [7:0] oo = 8'h00;
  reg [15:0] q = 16'hffff;
  task settle(input [2:0] k);
    begin
      if (oh[k] && rh[k]) oh[k] = 1'b0;
      if (oo[k] && ro[k]) oo[k] = 1'b0;
      if (!oh[k] && !oo[k]) begin
        if (!rh[k]) oh[k] = 1'b1;
        else if (!ro[k]) oo[k] = 1'b1;
      end
    end
  endtask
  always @(posedge rw_n_i) begin
    if (!sel_n_i) begin
      rh[idx_i] = wbit_i;
      settle(idx_i);
    end
  end
  always @(posedge o_wr_i) begin
    ro[o_idx_i] = o_val_i;
    settle(o_idx_i);
  end
  always @(negedge (sel_n_i | oe_n_i)) q = {16{~oh[idx_i]}};
  // Released bus shows inverse so stale data cannot pass
  assign data_o = (sel_n_i | oe_n_i) ? ~q : q;
  assign o_view_o = ~oo;
endmodule

// ===== bench/test_sem_host.sv
`timescale 1ns/10ps
module test_sem_host;
  reg clock_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg cmd_valid_i = 1'b0;
  reg [1:0] cmd_op_i = 2'h0;
  reg [2:0] cmd_index_i = 3'h0;
  reg o_wr = 1'b0;
  reg [2:0] o_idx = 3'h0;
  reg o_val = 1'b1;
  wire rdy, done, gnt, fv, sel_n, oe_n, rw_n, ce_n, doe_b;
  wire [13:0] addr;
  wire [15:0] wd, rd;
  wire [7:0] ov;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  sem_host dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_index_i(cmd_index_i), .cmd_ready_o(rdy), .done_o(done),
    .granted_o(gnt), .flag_value_o(fv), .chip_enable_n_o(ce_n), .flag_space_select_n_o(sel_n),
    .output_enable_n_o(oe_n), .read_write_n_o(rw_n), .flag_index_bits_o(addr),
    .data_o(wd), .data_oe_b_o(doe_b), .data_i(rd));
  sem_dev_model dev (.sel_n_i(sel_n), .oe_n_i(oe_n), .rw_n_i(rw_n), .idx_i(addr[2:0]),
    .wbit_i(wd[0]), .o_wr_i(o_wr), .o_idx_i(o_idx), .o_val_i(o_val), .data_o(rd),
    .o_view_o(ov));
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  task check(input [7:0] got, input [7:0] exp, input string what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task cmd(input [1:0] op, input [2:0] idx);
    begin
      @(posedge clock_i);
      while (rdy !== 1'b1) @(posedge clock_i);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_index_i <= idx;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      while (done !== 1'b1) @(posedge clock_i);
    end
  endtask
  task other(input [2:0] idx, input v);
    begin
      @(posedge clock_i);
      o_idx <= idx;
      o_val <= v;
      o_wr <= 1'b1;
      @(posedge clock_i);
      o_wr <= 1'b0;
    end
  endtask
  task t_reset;
    begin
      @(posedge clock_i);
      check({rdy, done, gnt, fv, sel_n, oe_n, rw_n, doe_b}, 8'h9f, "reset_pins");
      check(ce_n, 8'h01, "array_enable");
      $display("test reset done");
    end
  endtask
  task t_init;
    integer k;
    begin
      cmd(2'h3, 3'h0);
      check(ov, 8'h00, "handover");
      for (k = 0; k < 8; k = k + 1) other(k[2:0], 1'b1);
      @(posedge clock_i);
      check(ov, 8'hff, "free");
      $display("test init done");
    end
  endtask
  task t_claim;
    begin
      cmd(2'h1, 3'h5);
      check({gnt, fv, ov[5]}, 8'h05, "claim");
      other(3'h5, 1'b0);
      check(ov, 8'hff, "pending");
      cmd(2'h0, 3'h5);
      check(fv, 8'h00, "owned");
      cmd(2'h2, 3'h5);
      check(ov, 8'hdf, "pass");
      cmd(2'h1, 3'h5);
      check({gnt, fv, dev.rh[5]}, 8'h03, "refused");
      other(3'h5, 1'b1);
      check({dev.oh[5], ov[5]}, 8'h01, "withdrawn");
      $display("test claim done");
    end
  endtask
  task t_handover;
    begin
      other(3'h3, 1'b0);
      // Far side lets go while the host is still polling
      fork
        cmd(2'h1, 3'h3);
        begin
          repeat (20) @(posedge clock_i);
          other(3'h3, 1'b1);
        end
      join
      check({gnt, fv}, 8'h02, "handed");
      cmd(2'h2, 3'h3);
      check(ov, 8'hff, "freed3");
      $display("test handover done");
    end
  endtask
  task t_edge;
    begin
      other(3'h7, 1'b0);
      cmd(2'h0, 3'h7);
      check(fv, 8'h01, "read7");
      cmd(2'h1, 3'h0);
      check(gnt, 8'h01, "claim0");
      cmd(2'h2, 3'h0);
      check(ov, 8'h7f, "release0");
      check({ce_n, doe_b}, 8'h03, "idle_pins");
      $display("test edge done");
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_init;
    t_claim;
    t_handover;
    t_edge;
    final_report;
  end
endmodule
